// ===== dmc_pkg.sv
`default_nettype none
package dmc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned DEBOUNCE_MS    = 10;
  localparam int unsigned DEBOUNCE_CYC   = CYC_PER_MS * DEBOUNCE_MS;
  localparam int unsigned BLINK_MS       = 500;
  localparam int unsigned BLINK_CYC      = CYC_PER_MS * BLINK_MS;
  localparam int unsigned STEER_WIN_MS   = 20;
  localparam int unsigned STEER_WIN_CYC  = CYC_PER_MS * STEER_WIN_MS;
  localparam int unsigned MOVE_LIMIT_MS  = 1000;
  localparam int unsigned MOVE_LIMIT_CYC = CYC_PER_MS * MOVE_LIMIT_MS;
  localparam int unsigned UNFIXED_MS     = 200;
  localparam int unsigned UNFIXED_CYC    = CYC_PER_MS * UNFIXED_MS;
  localparam int unsigned ACT_COUNT      = 4;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  STATUS_OFS     = 8'h04;
  localparam logic [7:0]  SPEED_THR_OFS  = 8'h08;
  localparam logic [7:0]  CHASSIS_THR_OFS = 8'h0C;

  localparam int          CTRL_RUN_BIT        = 0;
  localparam int          CTRL_CLR_BIT        = 1;
  localparam int          CTRL_BAD_ROAD_LSB   = 8;
  localparam logic [31:0] CTRL_RST            = 32'h0000C001;

  localparam int          THR_HIGH_SPEED_LSB  = 0;
  localparam int          THR_ROLL_SPEED_LSB  = 8;
  localparam int          THR_LAUNCH_SPD_LSB  = 16;
  localparam logic [31:0] SPEED_THR_RST       = 32'h001E2878;

  localparam int          THR_ROLL_RATE_LSB   = 0;
  localparam int          THR_DECEL_LSB       = 8;
  localparam int          THR_THROTTLE_LSB    = 16;
  localparam int          THR_PITCH_LSB       = 24;
  localparam logic [31:0] CHASSIS_THR_RST     = 32'h50B4400A;

  localparam int          ST_FIRM_BIT    = 0;
  localparam int          ST_TARGET_LSB  = 1;
  localparam int          ST_POS_LSB     = 3;
  localparam int          ST_MOTOR_BIT   = 5;
  localparam int          ST_FAULT_BIT   = 6;
  localparam int          ST_DIR_BIT     = 7;
  localparam int          ST_RATE_LSB    = 8;
  localparam int          ST_FSM_LSB     = 16;

  // ****************************************************************
  // types
  // ****************************************************************
  // encoding equals {switch2, switch1}
  typedef enum logic [1:0] {
    STEP_UNFIXED = 2'h0,
    STEP_SOFT    = 2'h1,
    STEP_HARD    = 2'h2,
    STEP_MEDIUM  = 2'h3
  } dmc_step_t;

  typedef enum logic [1:0] {
    MOT_IDLE  = 2'h0,
    MOT_DRIVE = 2'h1,
    MOT_FAULT = 2'h3
  } dmc_motor_state_t;

endpackage : dmc_pkg
`default_nettype wire

// ===== dmc_debounce.sv
`timescale 1ns/10ps
`default_nettype none
module dmc_debounce #(
  parameter int unsigned WIDTH  = 3,
  parameter int unsigned STABLE = 1000000
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] raw,
  output var  logic [WIDTH-1:0] stable
);

  // a bit follows its input only after STABLE unchanged cycles
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic [31:0] cnt_reg;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_reg <= 32'h0;
          stable[g] <= 1'b0;
        end else if (raw[g] == stable[g]) begin
          cnt_reg <= 32'h0;
        end else if (cnt_reg >= 32'(STABLE - 1)) begin
          cnt_reg <= 32'h0;
          stable[g] <= raw[g];
        end else begin
          cnt_reg <= cnt_reg + 32'h1;
        end
      end
    end
  endgenerate

endmodule : dmc_debounce
`default_nettype wire

// ===== dmc_controller.sv
`timescale 1ns/10ps
`default_nettype none
module dmc_controller
  import dmc_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CNT   = dmc_pkg::DEBOUNCE_CYC,
  parameter int unsigned BLINK_CNT      = dmc_pkg::BLINK_CYC,
  parameter int unsigned STEER_WIN_CNT  = dmc_pkg::STEER_WIN_CYC,
  parameter int unsigned MOVE_LIMIT_CNT = dmc_pkg::MOVE_LIMIT_CYC,
  parameter int unsigned UNFIXED_CNT    = dmc_pkg::UNFIXED_CYC
) (
  input  wire logic                            hclk,
  input  wire logic                            hresetn,
  input  wire logic                            hsel,
  input  wire logic [31:0]                     haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     hwdata,
  input  wire logic                            hready,
  output var  logic                            hreadyout,
  output var  logic                            hresp,
  output var  logic [31:0]                     hrdata,
  input  wire logic                            mode_button,
  input  wire logic                            pos_contact1,
  input  wire logic                            pos_contact2,
  input  wire logic                            steer_pulse_a,
  input  wire logic                            steer_pulse_b,
  input  wire logic [7:0]                      speed_kmh,
  input  wire logic [7:0]                      throttle_pos,
  input  wire logic                            brake_on,
  input  wire logic [7:0]                      decel_level,
  input  wire logic [7:0]                      vertical_accel,
  output var  logic [dmc_pkg::ACT_COUNT-1:0]   motor_drive,
  output var  logic                            lamp_comfort,
  output var  logic                            lamp_firm
);
  import dmc_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [31:0]      ctrl_reg;
  logic [31:0]      speed_thr_reg;
  logic [31:0]      chassis_thr_reg;
  logic             wr_pend_reg;
  logic [7:0]       wr_addr_reg;
  logic             clr_pulse_reg;
  logic [2:0]       clean;
  logic             button_prev_reg;
  logic             button_press;
  logic             firm_mode_reg;
  dmc_step_t        pos_code;
  dmc_step_t        target_reg;
  dmc_step_t        target_next;
  dmc_motor_state_t state_reg;
  dmc_motor_state_t state_next;
  logic             steer_a_prev_reg;
  logic             steer_rise;
  logic             steer_dir_reg;
  logic [31:0]      steer_win_reg;
  logic [7:0]       steer_edges_reg;
  logic [7:0]       steer_rate_reg;
  logic [31:0]      move_cnt_reg;
  logic [31:0]      unfixed_cnt_reg;
  logic             move_hit;
  logic             unfixed_hit;
  logic             breakdown_reg;
  logic [31:0]      blink_cnt_reg;
  logic             blink_reg;
  logic             want_hard;
  logic             want_medium;
  logic             bad_road;
  logic [31:0]      status_word;
  logic [31:0]      read_mux;
  logic             addr_phase;

  // ****************************************************************
  // AHB-Lite slave: zero wait states, always OKAY
  // ****************************************************************
  assign addr_phase = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  always_comb begin
    status_word = 32'h0;
    status_word[ST_FIRM_BIT]               = firm_mode_reg;
    status_word[ST_TARGET_LSB +: 2]        = target_reg;
    status_word[ST_POS_LSB +: 2]           = pos_code;
    status_word[ST_MOTOR_BIT]              = (state_reg == MOT_DRIVE);
    status_word[ST_FAULT_BIT]              = breakdown_reg;
    status_word[ST_DIR_BIT]                = steer_dir_reg;
    status_word[ST_RATE_LSB +: 8]          = steer_rate_reg;
    status_word[ST_FSM_LSB +: 2]           = state_reg;
  end

  // unmapped offsets read zero; the clear bit is write-only
  always_comb begin
    case (haddr[7:0])
      CTRL_OFS:        read_mux = ctrl_reg;
      STATUS_OFS:      read_mux = status_word;
      SPEED_THR_OFS:   read_mux = speed_thr_reg;
      CHASSIS_THR_OFS: read_mux = chassis_thr_reg;
      default:         read_mux = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (addr_phase && !hwrite) begin
      hrdata <= read_mux;
    end else begin
      hrdata <= 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg        <= CTRL_RST;
      speed_thr_reg   <= SPEED_THR_RST;
      chassis_thr_reg <= CHASSIS_THR_RST;
      clr_pulse_reg   <= 1'b0;
    end else begin
      clr_pulse_reg <= 1'b0;
      if (wr_pend_reg) begin
        case (wr_addr_reg)
          CTRL_OFS: begin
            ctrl_reg      <= hwdata & ~(32'h1 << CTRL_CLR_BIT);
            clr_pulse_reg <= hwdata[CTRL_CLR_BIT];
          end
          SPEED_THR_OFS:   speed_thr_reg   <= hwdata;
          CHASSIS_THR_OFS: chassis_thr_reg <= hwdata;
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // inputs: debounce and press edge
  // ****************************************************************
  dmc_debounce #(
    .WIDTH  (3),
    .STABLE (DEBOUNCE_CNT)
  ) u_debounce (
    .hclk    (hclk),
    .hresetn (hresetn),
    .raw     ({pos_contact2, pos_contact1, mode_button}),
    .stable  (clean)
  );

  assign button_press = clean[0] && !button_prev_reg;
  assign pos_code     = dmc_step_t'({clean[2], clean[1]});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      button_prev_reg <= 1'b0;
      firm_mode_reg   <= 1'b0;
    end else begin
      button_prev_reg <= clean[0];
      if (button_press) begin
        firm_mode_reg <= !firm_mode_reg;
      end
    end
  end

  chk_toggle_press: assert property (@(posedge hclk) disable iff (!hresetn)
    button_press |=> firm_mode_reg != $past(firm_mode_reg)) else $error("press did not toggle mode");

  // ****************************************************************
  // steering pulses: direction and rate per window
  // ****************************************************************
  assign steer_rise = steer_pulse_a && !steer_a_prev_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      steer_a_prev_reg <= 1'b0;
      steer_dir_reg    <= 1'b0;
    end else begin
      steer_a_prev_reg <= steer_pulse_a;
      // b already high at a's rise means b leads by a quarter cycle
      if (steer_rise) begin
        steer_dir_reg <= steer_pulse_b;
      end
    end
  end

  chk_dir_decode: assert property (@(posedge hclk) disable iff (!hresetn)
    steer_rise |=> steer_dir_reg == $past(steer_pulse_b)) else $error("steer direction wrong");

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      steer_win_reg   <= 32'h0;
      steer_edges_reg <= 8'h00;
      steer_rate_reg  <= 8'h00;
    end else if (steer_win_reg >= 32'(STEER_WIN_CNT - 1)) begin
      steer_win_reg   <= 32'h0;
      steer_edges_reg <= 8'h00;
      steer_rate_reg  <= steer_edges_reg;
    end else begin
      steer_win_reg <= steer_win_reg + 32'h1;
      // saturate so a fast spin never wraps to a low rate
      if (steer_rise && steer_edges_reg != 8'hFF) begin
        steer_edges_reg <= steer_edges_reg + 8'h01;
      end
    end
  end

  // ****************************************************************
  // step selection
  // ****************************************************************
  always_comb begin
    want_hard = 1'b0;
    want_medium = 1'b0;
    if (steer_rate_reg >= chassis_thr_reg[THR_ROLL_RATE_LSB +: 8] &&
        speed_kmh >= speed_thr_reg[THR_ROLL_SPEED_LSB +: 8]) begin
      want_hard = 1'b1;
    end
    if (brake_on && decel_level >= chassis_thr_reg[THR_DECEL_LSB +: 8]) begin
      want_hard = 1'b1;
    end
    if (throttle_pos >= chassis_thr_reg[THR_THROTTLE_LSB +: 8] &&
        speed_kmh < speed_thr_reg[THR_LAUNCH_SPD_LSB +: 8]) begin
      want_hard = 1'b1;
    end
    if (speed_kmh >= speed_thr_reg[THR_HIGH_SPEED_LSB +: 8]) begin
      want_medium = 1'b1;
    end
    if (vertical_accel >= chassis_thr_reg[THR_PITCH_LSB +: 8]) begin
      want_medium = 1'b1;
    end
  end

  assign bad_road = vertical_accel >= ctrl_reg[CTRL_BAD_ROAD_LSB +: 8];

  // only SOFT, MEDIUM and HARD are ever commanded
  always_comb begin
    if (firm_mode_reg) begin
      target_next = STEP_HARD;
    end else if (want_hard && !bad_road) begin
      target_next = STEP_HARD;
    end else if (want_hard || want_medium) begin
      target_next = STEP_MEDIUM;
    end else begin
      target_next = STEP_SOFT;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      target_reg <= STEP_SOFT;
    end else begin
      target_reg <= target_next;
    end
  end

  chk_firm_hard: assert property (@(posedge hclk) disable iff (!hresetn)
    firm_mode_reg |=> target_reg == STEP_HARD) else $error("firm mode not HARD");
  chk_soft_default: assert property (@(posedge hclk) disable iff (!hresetn)
    !firm_mode_reg && !want_hard && !want_medium |=> target_reg == STEP_SOFT) else $error("idle comfort not SOFT");
  chk_bad_road_cap: assert property (@(posedge hclk) disable iff (!hresetn)
    !firm_mode_reg && bad_road |=> target_reg != STEP_HARD) else $error("HARD on bad road");

  // ****************************************************************
  // actuator motor
  // ****************************************************************
  always_comb begin
    case (state_reg)
      MOT_IDLE: begin
        if (ctrl_reg[CTRL_RUN_BIT] && !breakdown_reg && pos_code != target_reg) begin
          state_next = MOT_DRIVE;
        end else begin
          state_next = MOT_IDLE;
        end
      end
      MOT_DRIVE: begin
        if (breakdown_reg) begin
          state_next = MOT_FAULT;
        end else if (pos_code == target_reg || !ctrl_reg[CTRL_RUN_BIT]) begin
          state_next = MOT_IDLE;
        end else begin
          state_next = MOT_DRIVE;
        end
      end
      MOT_FAULT: begin
        state_next = breakdown_reg ? MOT_FAULT : MOT_IDLE;
      end
      default: state_next = MOT_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= MOT_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // one drive flop per actuator, all loaded from the same decision
  genvar a;
  generate
    for (a = 0; a < ACT_COUNT; a++) begin : g_act
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          motor_drive[a] <= 1'b0;
        end else begin
          motor_drive[a] <= (state_next == MOT_DRIVE);
        end
      end
    end
  endgenerate

  chk_motor_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    pos_code == target_reg |=> motor_drive == '0) else $error("drive kept at target");
  chk_all_together: assert property (@(posedge hclk) disable iff (!hresetn)
    (motor_drive == '0) || (motor_drive == '1)) else $error("actuators driven apart");

  // ****************************************************************
  // breakdown detection
  // ****************************************************************
  assign move_hit    = (state_reg == MOT_DRIVE) && move_cnt_reg >= 32'(MOVE_LIMIT_CNT - 1);
  assign unfixed_hit = unfixed_cnt_reg >= 32'(UNFIXED_CNT - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      move_cnt_reg    <= 32'h0;
      unfixed_cnt_reg <= 32'h0;
    end else begin
      move_cnt_reg    <= (state_reg == MOT_DRIVE && !move_hit) ? move_cnt_reg + 32'h1 : 32'h0;
      unfixed_cnt_reg <= (pos_code == STEP_UNFIXED && !unfixed_hit) ? unfixed_cnt_reg + 32'h1 : 32'h0;
    end
  end

  // a new fault in the clearing cycle wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      breakdown_reg <= 1'b0;
    end else if (move_hit || unfixed_hit) begin
      breakdown_reg <= 1'b1;
    end else if (clr_pulse_reg) begin
      breakdown_reg <= 1'b0;
    end
  end

  chk_fault_set: assert property (@(posedge hclk) disable iff (!hresetn)
    move_hit || unfixed_hit |=> breakdown_reg ##1 state_reg != MOT_DRIVE) else $error("fault not raised");

  // ****************************************************************
  // mode lamps
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt_reg <= 32'h0;
      blink_reg     <= 1'b0;
    end else if (!breakdown_reg) begin
      blink_cnt_reg <= 32'h0;
      blink_reg     <= 1'b1;
    end else if (blink_cnt_reg >= 32'(BLINK_CNT - 1)) begin
      blink_cnt_reg <= 32'h0;
      blink_reg     <= !blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamp_comfort <= 1'b0;
      lamp_firm    <= 1'b0;
    end else if (breakdown_reg) begin
      lamp_comfort <= blink_reg;
      lamp_firm    <= blink_reg;
    end else begin
      lamp_comfort <= !firm_mode_reg;
      lamp_firm    <= firm_mode_reg;
    end
  end

  chk_lamp_modes: assert property (@(posedge hclk) disable iff (!hresetn)
    !breakdown_reg && $past(hresetn) |=> lamp_firm == $past(firm_mode_reg) && lamp_comfort != lamp_firm) else $error("lamp mismatch");
  chk_blink_both: assert property (@(posedge hclk) disable iff (!hresetn)
    breakdown_reg |=> lamp_comfort == lamp_firm) else $error("lamps not blinking together");

endmodule : dmc_controller
`default_nettype wire

// ===== dmc_actuator_model.sv
`timescale 1ns/10ps
`default_nettype none
module dmc_actuator_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [3:0] drive,
  input  wire logic       stuck,
  input  wire logic [7:0] seg_len,
  output var  logic       contact1,
  output var  logic       contact2
);
  logic [2:0] pos_reg;
  logic [7:0] seg_reg;

  // ****************************************************************
  // rotation
  // ****************************************************************
  // turns only when all four lines drive at once; stuck models a jam
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_reg <= 3'h0;
      seg_reg <= 8'h00;
    end else if (drive == 4'hF && !stuck) begin
      if (seg_reg + 8'h01 >= seg_len) begin
        seg_reg <= 8'h00;
        pos_reg <= (pos_reg == 3'h4) ? 3'h0 : pos_reg + 3'h1;
      end else begin
        seg_reg <= seg_reg + 8'h01;
      end
    end
  end

  // one turn: soft, hard, medium, hard, unfixed
  always_comb begin
    case (pos_reg)
      3'h0:       {contact1, contact2} = 2'h2;
      3'h2:       {contact1, contact2} = 2'h3;
      3'h1, 3'h3: {contact1, contact2} = 2'h1;
      default:    {contact1, contact2} = 2'h0;
    endcase
  end
endmodule : dmc_actuator_model
`default_nettype wire

// ===== dmc_controller_bench.sv
`timescale 1ns/10ps
`default_nettype none
module dmc_controller_bench;
  import dmc_pkg::*;
  localparam int BLINK = 8;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        mode_button = 1'b0;
  logic        steer_pulse_a = 1'b0;
  logic        steer_pulse_b = 1'b0;
  logic        brake_on = 1'b0;
  logic        stuck = 1'b0;
  logic        pos_contact1;
  logic        pos_contact2;
  logic        lamp_comfort;
  logic        lamp_firm;
  logic        lamp_seen;
  logic [7:0]  speed_kmh = 8'h00;
  logic [7:0]  throttle_pos = 8'h00;
  logic [7:0]  decel_level = 8'h00;
  logic [7:0]  vertical_accel = 8'h00;
  logic [7:0]  seg_len = 8'h0A;
  logic [3:0]  motor_drive;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  // {speed, throttle, brake decel, vertical, expected step}
  logic [33:0] tbl [8] = '{{8'h00, 8'h00, 8'h00, 8'h00, STEP_SOFT}, {8'h78, 8'h00, 8'h00, 8'h00, STEP_MEDIUM},
                           {8'h77, 8'h00, 8'h00, 8'h00, STEP_SOFT}, {8'h00, 8'h00, 8'h40, 8'h00, STEP_HARD},
                           {8'h1D, 8'hB4, 8'h00, 8'h00, STEP_HARD}, {8'h1E, 8'hB4, 8'h00, 8'h00, STEP_SOFT},
                           {8'h00, 8'h00, 8'h00, 8'h50, STEP_MEDIUM}, {8'h00, 8'h00, 8'h40, 8'hC0, STEP_MEDIUM}};

  always #5 hclk = ~hclk;

  dmc_controller #(.DEBOUNCE_CNT(4), .BLINK_CNT(BLINK), .STEER_WIN_CNT(16), .MOVE_LIMIT_CNT(64),
                   .UNFIXED_CNT(32)) u_dmc_controller (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mode_button(mode_button), .pos_contact1(pos_contact1), .pos_contact2(pos_contact2),
    .steer_pulse_a(steer_pulse_a), .steer_pulse_b(steer_pulse_b), .speed_kmh(speed_kmh),
    .throttle_pos(throttle_pos), .brake_on(brake_on), .decel_level(decel_level),
    .vertical_accel(vertical_accel), .motor_drive(motor_drive), .lamp_comfort(lamp_comfort),
    .lamp_firm(lamp_firm));

  dmc_actuator_model u_dmc_actuator_model (.hclk(hclk), .hresetn(hresetn), .drive(motor_drive),
    .stuck(stuck), .seg_len(seg_len), .contact1(pos_contact1), .contact2(pos_contact2));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // single AHB-Lite word transfer; read data taken at the data phase edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(32'(hresp), 32'h0);
  endtask : ahb

  task automatic press();
    @(posedge hclk);
    mode_button <= 1'b1;
    repeat (8) @(posedge hclk);
    mode_button <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask : press

  // wait for the drive to stop, then the stop position must be the target
  task automatic settle(input logic [1:0] exp);
    int n;
    n = 0;
    // a cleared breakdown passes through idle first, so drive may start late
    repeat (5) @(posedge hclk);
    while (motor_drive !== 4'h0 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    ahb(1'b0, 32'(STATUS_OFS), 32'h0);
    chk(32'(rd[ST_TARGET_LSB +: 2]), 32'(exp));
    chk(32'(rd[ST_POS_LSB +: 2]), 32'(exp));
  endtask : settle

  task automatic quad(input logic dir);
    @(posedge hclk);
    steer_pulse_a <= ~dir;
    steer_pulse_b <= dir;
    @(posedge hclk);
    {steer_pulse_a, steer_pulse_b} <= 2'h3;
    @(posedge hclk);
    steer_pulse_a <= dir;
    steer_pulse_b <= ~dir;
    @(posedge hclk);
    {steer_pulse_a, steer_pulse_b} <= 2'h0;
  endtask : quad

  // ****************************************************************
  // sequence
  // ****************************************************************
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 10000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({lamp_comfort, lamp_firm}, 2'h2);
    repeat (8) @(posedge hclk);
    ahb(1'b0, 32'(CTRL_OFS), 32'h0);
    chk(rd, CTRL_RST);
    ahb(1'b0, 32'(SPEED_THR_OFS), 32'h0);
    chk(rd, SPEED_THR_RST);
    ahb(1'b0, 32'(CHASSIS_THR_OFS), 32'h0);
    chk(rd, CHASSIS_THR_RST);
    ahb(1'b1, 32'h10, 32'hFFFFFFFF);
    ahb(1'b0, 32'h10, 32'h0);
    chk(rd, 32'h0);
    foreach (tbl[i]) begin
      {speed_kmh, throttle_pos, decel_level, vertical_accel} <= tbl[i][33:2];
      brake_on <= (tbl[i][17:10] != 8'h00);
      settle(tbl[i][1:0]);
    end
    ahb(1'b1, 32'(CHASSIS_THR_OFS), 32'h50B44001);
    speed_kmh <= 8'h28;
    {throttle_pos, decel_level, vertical_accel} <= 24'h0;
    brake_on <= 1'b0;
    for (int dir = 1; dir >= 0; dir--) begin
      fork
        repeat (20) quad(1'(dir));
        begin
          repeat (40) @(posedge hclk);
          ahb(1'b0, 32'(STATUS_OFS), 32'h0);
          chk(32'(rd[ST_DIR_BIT]), 32'(dir));
          chk(32'(rd[ST_TARGET_LSB +: 2]), 32'(STEP_HARD));
        end
      join
    end
    speed_kmh <= 8'h00;
    settle(STEP_SOFT);
    seg_len <= 8'h28;
    press();
    chk({lamp_comfort, lamp_firm}, 2'h1);
    chk(32'(motor_drive), 32'hF);
    settle(STEP_HARD);
    seg_len <= 8'h0A;
    press();
    chk({lamp_comfort, lamp_firm}, 2'h2);
    settle(STEP_SOFT);
    ahb(1'b1, 32'(CTRL_OFS), 32'h0000C000);
    press();
    repeat (20) @(posedge hclk);
    chk(32'(motor_drive), 32'h0);
    ahb(1'b1, 32'(CTRL_OFS), 32'h0000C001);
    settle(STEP_HARD);
    // jammed actuator: the move limit must end the drive
    stuck <= 1'b1;
    press();
    repeat (80) @(posedge hclk);
    ahb(1'b0, 32'(STATUS_OFS), 32'h0);
    chk(32'(rd[ST_FAULT_BIT]), 32'h1);
    chk(32'(motor_drive), 32'h0);
    @(posedge hclk);
    lamp_seen = lamp_comfort;
    chk(32'(lamp_firm), 32'(lamp_seen));
    repeat (BLINK) @(posedge hclk);
    chk({lamp_comfort, lamp_firm}, {2{~lamp_seen}});
    stuck <= 1'b0;
    ahb(1'b1, 32'(CTRL_OFS), 32'h0000C003);
    settle(STEP_SOFT);
    chk(32'(rd[ST_FAULT_BIT]), 32'h0);
    end_of_test();
  end
endmodule : dmc_controller_bench
`default_nettype wire
